// File: include/bts_map.svh
// register offsets, opcodes and decode constants of the bit-test-skip unit
// assumes inclusion by bare name from the design file and the bench
`ifndef BTS_MAP_SVH
`define BTS_MAP_SVH
`define BTS_OFF_CTRL    8'h00
`define BTS_OFF_INSTR   8'h04
`define BTS_OFF_STATUS  8'h08
`define BTS_OFF_IDXBASE 8'h0c
`define BTS_OP_SKIP_CLR 4'hb
`define BTS_OP_SKIP_SET 4'ha
`define BTS_IDX_LIMIT   8'h5f
`define BTS_ACC_SPLIT   8'h80
`define BTS_ACC_HIGH    4'hf
`define BTS_ACC_LOW     4'h0
`define BTS_PH_LAST     2'h3
`define BTS_PH_READ     2'h1
`define BTS_PH_PROC     2'h2
`define BTS_RESP_OKAY   2'h0
`define BTS_RESP_SLVERR 2'h2
`define BTS_CYC_ONE     2'h1
`define BTS_CYC_TWO     2'h2
`define BTS_CYC_THREE   2'h3
`define BTS_PH_FIRST    2'h0
`endif

// File: include/bts_pkg.sv
// types shared by the bit-test-skip unit
// assumes nothing beyond a SystemVerilog compiler
package bts_pkg;
  typedef enum logic [1:0] {BTS_IDLE, BTS_EXEC, BTS_NOP} bts_state_t;
endpackage

// File: hdl/bts_exec.sv
// bit-test-and-skip execution unit with an axi4-lite register slave
// assumes data memory answers a read one mclk after dmem_rd, same clock domain
//
// How it works
// - skip-if-clear opcode skips next instruction when the tested bit is 0
// - skip-if-set opcode skips next instruction when the tested bit is 1
// - a skip discards the prefetched word and runs a nop cycle; two cycles
// - access flag 0 resolves the address inside the access bank
// - access flag 1 takes the bank from the bank select register
// - extended set, flag 0, address up to 95: indexed literal offset
// - skip over a two-word instruction makes three cycles in total
`timescale 1ns/100ps
`include "bts_map.svh"
module bts_exec #(
  parameter int BANK_W = 4                // width of the bank select register
) (
  input  wire logic        mclk,          // 250 mhz core clock
  input  wire logic        sys_rst,       // synchronous reset, active high
  input  wire logic        ce,            // clock enable, freezes all state when low
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic [11:0]      dmem_addr,     // resolved file register address
  output logic             dmem_rd,       // one-cycle read strobe
  input  wire logic [7:0]  dmem_rdata,    // file register contents, next cycle
  output logic             fetch_discard, // pulse: drop the prefetched word
  output logic             nop_active     // level: nop cycle in progress
);
  bts_pkg::bts_state_t state_q, state_d;

  logic [1:0]        ph_q;
  logic [1:0]        nops_q;
  logic [15:0]       op_q;
  logic              two_word_q;
  logic              ext_en_q;
  logic [BANK_W-1:0] bsr_q;
  logic [11:0]       idx_base_q;
  logic              bit_q, skip_q, idx_q, err_q;
  logic [1:0]        cyc_q;
  logic [11:0]       addr_q;
  logic              rd_q, disc_q;
  logic              aw_q, w_q, bv_q, rv_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q, rdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;

  // opcode field split
  wire [3:0] new_opc   = wdata_q[15:12];
  wire [3:0] opc       = op_q[15:12];
  wire [2:0] bsel      = op_q[11:9];
  wire       acc_flag  = op_q[8];
  wire [7:0] faddr     = op_q[7:0];
  wire       opc_clr   = (opc == `BTS_OP_SKIP_CLR);
  wire       new_legal = (new_opc == `BTS_OP_SKIP_CLR) || (new_opc == `BTS_OP_SKIP_SET);

  // address resolution: banked, access bank, or indexed literal offset
  wire       use_idx   = ext_en_q && !acc_flag && (faddr <= `BTS_IDX_LIMIT);
  wire [11:0] acc_addr = (faddr < `BTS_ACC_SPLIT) ? {`BTS_ACC_LOW, faddr}
                                                  : {`BTS_ACC_HIGH, faddr};
  wire [11:0] bank_addr = 12'(({BANK_W'(0), 8'h00} | {bsr_q, faddr}));
  wire [11:0] idx_addr  = idx_base_q + {4'h0, faddr};
  wire [11:0] res_addr  = acc_flag ? bank_addr : (use_idx ? idx_addr : acc_addr);

  // skip decision from the sampled bit
  wire       tbit      = dmem_rdata[bsel];
  wire       skip_now  = opc_clr ? !tbit : tbit;
  wire       ph_end    = (ph_q == `BTS_PH_LAST);
  wire       busy      = (state_q != bts_pkg::BTS_IDLE);

  // bus decode
  wire       wr_go     = aw_q && w_q && !bv_q;
  wire       wr_ctrl   = wr_go && (awaddr_q == `BTS_OFF_CTRL);
  wire       wr_instr  = wr_go && (awaddr_q == `BTS_OFF_INSTR);
  wire       wr_base   = wr_go && (awaddr_q == `BTS_OFF_IDXBASE);
  wire       wr_ok     = wr_ctrl || wr_base || (wr_instr && !busy && new_legal);
  wire       start     = wr_instr && !busy && new_legal;
  wire       rd_go     = s_axi_arvalid && !rv_q;
  wire       rd_map    = (s_axi_araddr == `BTS_OFF_CTRL) || (s_axi_araddr == `BTS_OFF_INSTR)
                      || (s_axi_araddr == `BTS_OFF_STATUS) || (s_axi_araddr == `BTS_OFF_IDXBASE);
  wire [31:0] status_w = {12'h000, addr_q, cyc_q, 1'b0, err_q, idx_q, bit_q, skip_q, busy};
  wire [31:0] rd_mux   = (s_axi_araddr == `BTS_OFF_CTRL) ?
                           32'({bsr_q, 7'h00, ext_en_q}) :
                         (s_axi_araddr == `BTS_OFF_INSTR) ? {15'h0000, two_word_q, op_q} :
                         (s_axi_araddr == `BTS_OFF_STATUS) ? status_w :
                         (s_axi_araddr == `BTS_OFF_IDXBASE) ? {20'h00000, idx_base_q} :
                         32'h0000_0000;

  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign dmem_addr     = addr_q;
  assign dmem_rd       = rd_q;
  assign fetch_discard = disc_q;
  assign nop_active    = (state_q == bts_pkg::BTS_NOP);

  // next state: one four-phase exec cycle, then one or two nop cycles on skip
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      bts_pkg::BTS_IDLE: if (start) state_d = bts_pkg::BTS_EXEC;
      bts_pkg::BTS_EXEC: if (ph_end) state_d = skip_q ? bts_pkg::BTS_NOP
                                                      : bts_pkg::BTS_IDLE;
      bts_pkg::BTS_NOP:  if (ph_end && nops_q == `BTS_CYC_ONE)
                           state_d = bts_pkg::BTS_IDLE;
    endcase
  end

  // write channel: address and data taken in either order, answer after both
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; bresp_q <= `BTS_RESP_OKAY;
      awaddr_q <= 8'h00; wdata_q <= 32'h0000_0000; wstrb_q <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && !aw_q) begin aw_q <= 1'b1; awaddr_q <= s_axi_awaddr; end
      if (s_axi_wvalid && !w_q)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;    // strobes are only valid with wvalid, so keep them
      end
      if (wr_go)
      begin
        bv_q <= 1'b1;
        bresp_q <= wr_ok ? `BTS_RESP_OKAY : `BTS_RESP_SLVERR;
      end
      if (bv_q && s_axi_bready) begin bv_q <= 1'b0; aw_q <= 1'b0; w_q <= 1'b0; end
    end
  end

  // read channel: one cycle to answer, slverr on unmapped offsets
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rv_q <= 1'b0; rdata_q <= 32'h0000_0000; rresp_q <= `BTS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_go)
      begin
        rv_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_map ? `BTS_RESP_OKAY : `BTS_RESP_SLVERR;
      end
      else if (rv_q && s_axi_rready) rv_q <= 1'b0;
    end
  end

  // control registers written by software; byte lane 0 and 1 only
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ext_en_q <= 1'b0; bsr_q <= '0; idx_base_q <= 12'h000;
    end
    else if (ce)
    begin
      if (wr_ctrl && wstrb_q[0]) ext_en_q <= wdata_q[0];
      if (wr_ctrl && wstrb_q[1]) bsr_q <= wdata_q[8 +: BANK_W];
      if (wr_base) idx_base_q <= wdata_q[11:0];
    end
  end

  // execution sequencer: q1 decode, q2 read, q3 process, q4 discard on skip or none
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_q <= bts_pkg::BTS_IDLE; ph_q <= 2'h0; nops_q <= 2'h0; op_q <= 16'h0000;
      two_word_q <= 1'b0; bit_q <= 1'b0; skip_q <= 1'b0; idx_q <= 1'b0;
      err_q <= 1'b0; cyc_q <= 2'h0; addr_q <= 12'h000; rd_q <= 1'b0; disc_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      rd_q <= 1'b0;
      disc_q <= 1'b0;
      if (wr_instr && !busy) err_q <= !new_legal;
      if (start)
      begin
        op_q <= wdata_q[15:0];
        two_word_q <= wdata_q[16];
        ph_q <= 2'h0;
        skip_q <= 1'b0;
        cyc_q <= `BTS_CYC_ONE;
      end
      else if (busy)
        ph_q <= ph_q + 2'h1;
      if (state_q == bts_pkg::BTS_EXEC && ph_q == `BTS_PH_FIRST)
      begin
        addr_q <= res_addr;
        idx_q <= use_idx;
        rd_q <= 1'b1;
      end
      // memory data stands only in the cycle after the strobe, so sample it there
      if (state_q == bts_pkg::BTS_EXEC && ph_q == `BTS_PH_PROC)
      begin
        bit_q <= tbit;
        skip_q <= skip_now;
      end
      if (state_q == bts_pkg::BTS_EXEC && ph_end && skip_q)
      begin
        disc_q <= 1'b1;
        nops_q <= two_word_q ? `BTS_CYC_TWO : `BTS_CYC_ONE;
        cyc_q <= two_word_q ? `BTS_CYC_THREE : `BTS_CYC_TWO;
      end
      if (state_q == bts_pkg::BTS_NOP && ph_end) nops_q <= nops_q - 2'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst || !ce);

  chk_clear_skip_bit: assert property (
    (state_q == bts_pkg::BTS_EXEC && ph_q == `BTS_PH_PROC && opc_clr)
    |=> bit_q == $past(dmem_rdata[bsel]) && skip_q == !bit_q)
    else $error("skip-if-clear decision wrong");
  chk_set_skip_bit: assert property (
    (state_q == bts_pkg::BTS_EXEC && ph_q == `BTS_PH_PROC && !opc_clr)
    |=> bit_q == $past(dmem_rdata[bsel]) && skip_q == bit_q)
    else $error("skip-if-set decision wrong");
  chk_skip_discard_nop: assert property (
    (state_q == bts_pkg::BTS_EXEC && ph_end && skip_q)
    |=> fetch_discard && nop_active ##1 !fetch_discard)
    else $error("skip did not discard and run a nop");
  chk_no_skip_idle: assert property (
    (state_q == bts_pkg::BTS_EXEC && ph_end && !skip_q)
    |=> !nop_active && !fetch_discard)
    else $error("nop without skip");
  chk_access_bank_addr: assert property (
    $rose(dmem_rd) && !acc_flag && !idx_q |-> dmem_addr[7:0] == faddr
    && dmem_addr[11:8] == ((faddr < `BTS_ACC_SPLIT) ? `BTS_ACC_LOW : `BTS_ACC_HIGH))
    else $error("access bank address wrong");
  chk_bank_select_addr: assert property (
    dmem_rd && acc_flag |-> dmem_addr[11:8] == 4'(bsr_q) && dmem_addr[7:0] == faddr)
    else $error("banked address wrong");
  chk_indexed_offset: assert property (
    dmem_rd && ext_en_q && !acc_flag && faddr <= `BTS_IDX_LIMIT
    |-> idx_q && dmem_addr == idx_base_q + {4'h0, faddr})
    else $error("indexed literal offset address wrong");
  chk_three_cycle_skip: assert property (
    (state_q == bts_pkg::BTS_EXEC && ph_end && skip_q && two_word_q)
    |=> nop_active [*8] ##1 !nop_active)
    else $error("two-word skip not three cycles");
  chk_illegal_opcode: assert property ((wr_instr && !busy && !new_legal) |=> !busy && err_q)
    else $error("illegal opcode started execution");

  cov_skip_one: cover property (state_q == bts_pkg::BTS_EXEC && ph_end && skip_q && !two_word_q);
  cov_skip_two: cover property (state_q == bts_pkg::BTS_EXEC && ph_end && skip_q && two_word_q);
  cov_no_skip:  cover property (state_q == bts_pkg::BTS_EXEC && ph_end && !skip_q);
  cov_indexed:  cover property (dmem_rd && idx_q);
endmodule // bts_exec

// File: dv/bts_dmem_model.sv
// data memory model facing the bit-test-skip unit
// assumes reads are strobed by dmem_rd and answered one mclk later
`timescale 1ns/100ps
module bts_dmem_model (
  input  wire logic        mclk,      // core clock
  input  wire logic [11:0] dmem_addr, // resolved file address
  input  wire logic        dmem_rd,   // read strobe
  output logic [7:0]       dmem_rdata // contents, valid the cycle after the strobe
);
  initial dmem_rdata = 8'h00;
  // contents depend on bank bits too, so a wrong bank gives wrong data;
  // outside the answer cycle the bus toggles instead of holding its value
  always @(posedge mclk)
    if (dmem_rd)
      dmem_rdata <= dmem_addr[7:0] ^ {dmem_addr[11:8], 4'h5};
    else
      dmem_rdata <= ~dmem_rdata;
endmodule // bts_dmem_model

// File: dv/test_bit_test_skip_exec.sv
// self-checking bench for the bit-test-skip unit over axi4-lite
// assumes bts_exec, its map header and the data memory model
`timescale 1ns/100ps
`include "bts_map.svh"
module test_bit_test_skip_exec;
  logic mclk = 1'b0, sys_rst = 1'b1, ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rdat;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, dmem_rd, fetch_discard, nop_active;
  logic [1:0] bresp, rresp, rs;
  logic [11:0] dmem_addr;
  logic [31:0] st;
  int mismatches = 0, compares = 0, ndisc = 0, nnop = 0, nrd = 0;

  bts_exec u_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_rdata(rdat), .fetch_discard(fetch_discard), .nop_active(nop_active));
  bts_dmem_model u_mem (.mclk(mclk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_rdata(rdat));

  initial forever #2 mclk = ~mclk;
  // count pulses and nop cycles seen at the far side
  always @(posedge mclk)
    if (!sys_rst)
    begin
      ndisc += int'(fetch_discard);
      nnop += int'(nop_active);
      nrd += int'(dmem_rd);
    end

  task automatic end_sim;
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask
  // run one bit test and compare status, discards, nops and reads
  task automatic run(input logic [3:0] op, input logic [2:0] b, input logic a,
                     input logic [7:0] f, input logic two, input logic [11:0] ea,
                     input logic idx);
    logic [7:0] mv;
    logic bt, sk;
    logic [1:0] cyc;
    int d0, n0, r0;
    mv = ea[7:0] ^ {ea[11:8], 4'h5};
    bt = mv[b];
    sk = (op == `BTS_OP_SKIP_CLR) ? !bt : bt;
    cyc = sk ? (two ? 2'h3 : 2'h2) : 2'h1;
    d0 = ndisc; n0 = nnop; r0 = nrd;
    wr(`BTS_OFF_INSTR, {15'h0, two, op, b, a, f}, rs);
    chk("instr_resp", 32'(`BTS_RESP_OKAY), 32'(rs));
    st = 32'h1;
    while (st[0] !== 1'b0) rd(`BTS_OFF_STATUS, st, rs);
    chk("status", {12'h0, ea, cyc, 2'b0, idx, bt, sk, 1'b0}, st);
    chk("discards", 32'(sk), 32'(ndisc - d0));
    chk("nop_cycles", sk ? (two ? 32'h8 : 32'h4) : 32'h0, 32'(nnop - n0));
    chk("reads", 32'h1, 32'(nrd - r0));
    $display("test done: op %h bit %0d f %h", op, b, f);
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_sim();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    rd(`BTS_OFF_STATUS, st, rs);
    chk("status_reset", 32'h0, st);
    rd(8'h10, st, rs);
    chk("unmapped_resp", 32'(`BTS_RESP_SLVERR), 32'(rs));
    $display("test done: reset and unmapped");
    // bank from bank select register, then access bank high half
    wr(`BTS_OFF_CTRL, 32'h0000_0300, rs);
    run(`BTS_OP_SKIP_CLR, 3'd1, 1'b1, 8'h20, 1'b0, 12'h320, 1'b0);
    run(`BTS_OP_SKIP_SET, 3'd2, 1'b0, 8'h90, 1'b1, 12'hf90, 1'b0);
    // extended set: boundary 95 indexed, 96 falls back to access bank
    wr(`BTS_OFF_IDXBASE, 32'h0000_0100, rs);
    wr(`BTS_OFF_CTRL, 32'h0000_0301, rs);
    rd(`BTS_OFF_CTRL, st, rs);
    chk("ctrl_readback", 32'h0000_0301, st);
    rd(`BTS_OFF_IDXBASE, st, rs);
    chk("base_readback", 32'h0000_0100, st);
    run(`BTS_OP_SKIP_CLR, 3'd0, 1'b0, 8'h5f, 1'b0, 12'h15f, 1'b1);
    run(`BTS_OP_SKIP_CLR, 3'd0, 1'b0, 8'h60, 1'b0, 12'h060, 1'b0);
    run(`BTS_OP_SKIP_SET, 3'd3, 1'b1, 8'h5f, 1'b0, 12'h35f, 1'b0);
    // freeze with ce low in mid-execution, then a second start while busy
    wr(`BTS_OFF_INSTR, {16'h0, `BTS_OP_SKIP_SET, 3'd3, 1'b1, 8'h5f}, rs);
    ce <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("frozen_rd", 32'h1, 32'(dmem_rd));
    ce <= 1'b1;
    wr(`BTS_OFF_INSTR, {16'h0, `BTS_OP_SKIP_SET, 3'd3, 1'b1, 8'h5f}, rs);
    chk("busy_resp", 32'(`BTS_RESP_SLVERR), 32'(rs));
    st = 32'h1;
    while (st[0] !== 1'b0) rd(`BTS_OFF_STATUS, st, rs);
    chk("status_frozen", {12'h0, 12'h35f, 2'h2, 6'h06}, st);
    $display("test done: freeze and busy refusal");
    wr(`BTS_OFF_INSTR, 32'h0000_3000, rs);
    chk("illegal_resp", 32'(`BTS_RESP_SLVERR), 32'(rs));
    rd(`BTS_OFF_STATUS, st, rs);
    chk("illegal_flag", 32'h1, 32'(st[4]));
    $display("test done: illegal opcode");
    end_sim();
  end
endmodule // test_bit_test_skip_exec
